// ---- src/jmc_cfg.svh ----
// Register offsets, field positions, reset values and fixed ILAS values
`ifndef JMC_CFG_SVH
`define JMC_CFG_SVH

`define JMC_OFF_MODE      4'h0
`define JMC_OFF_KFIELD    4'h1
`define JMC_OFF_DEVID     4'h2
`define JMC_OFF_LINKCTL   4'h3
`define JMC_OFF_INMUX     4'h4
`define JMC_OFF_DERIVED   4'h5
`define JMC_OFF_RATE      4'h6
`define JMC_OFF_CHECKSUM  4'h7

`define JMC_RST_MODE      8'h00
`define JMC_RST_KFIELD    8'h1f
`define JMC_RST_DEVID     8'h00
`define JMC_RST_LINKCTL   8'h00
`define JMC_RST_INMUX     8'h00

`define JMC_BIT_SCR       0
`define JMC_BIT_DUALIN    0

`define JMC_JESDV         3'h1
`define JMC_SUBCLASSV     3'h1
`define JMC_E_64B66B      8'h01
`define JMC_LANES_PER_LINK 8

`endif

// ---- src/jmc_pkg.sv ----
// Types for the mode configuration and ILAS parameter block
package jmc_pkg;

    typedef enum logic [1:0]
    {
        JMC_ENC_8B10B  = 2'b01,
        JMC_ENC_64B66B = 2'b10
    } jmc_enc_t;

    // R factor as ratio, bits per clock = r_x32 / 32
    typedef struct packed
    {
        logic       valid;
        logic       des;
        jmc_enc_t   enc;
        logic [3:0] lanes;
        logic [7:0] f;
        logic [7:0] s;
        logic [7:0] r_x32;
    } jmc_mode_t;

endpackage

// ---- src/jmc_mode_ilas.sv ----
// Mode decode, link parameter derivation and ILAS field generation
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ns
`include "jmc_cfg.svh"

// Operation
// (RQ1) Interleaved mode samples at twice device clock
// (RQ2) Interleave needs single mode and both inputs
// (RQ3) Interleave keeps single-channel processing and link
// (RQ4) All link parameters derive from mode select; the code takes 8b/10b K from kfield and scrambling from linkctl
// (RQ5) Interleave flag one single, zero dual
// (RQ6) Line rate is clock times R
// (RQ7) K from field in 8b/10b only
// (RQ8) E fixed one in 64b/66b
// (RQ9) ILAS sent only in 8b/10b modes
// (RQ10) Adjust count and direction sent zero
// (RQ11) BID, CF, HD, reserved fields zero
// (RQ12) Control bits per sample sent zero
// (RQ13) Device identifier equals written register
// (RQ14) Each lane gets distinct lane identifier
// (RQ15) Scrambler flag follows link control setting
// (RQ16) Derive L, F, M, N, N', S
// (RQ17) M sets packing, not channel count
// (RQ18) Checksum is field sum modulo 256
// (RQ19) Revision and subclass fields both one
// (RQ20) Receiver recomputes checksum, flags mismatch
// (RQ21) 64b/66b K equals 8*32*E/F
// (RQ22) Only listed modes; upper lanes powered down
module jmc_mode_ilas
(
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [2:0]  lane_sel_i,
    output logic      [7:0]  rdata_o,
    output logic             ilas_en_o,
    output logic             scramble_en_o,
    output logic             sample_2x_o,
    output logic             dual_input_o,
    output logic      [7:0]  lane_pwr_o,
    output logic      [7:0]  k_o,
    output logic      [7:0]  pll_ratio_x32_o,
    output logic      [7:0]  ilas_lid_o,
    output logic      [7:0]  ilas_checksum_o
);

    logic [7:0] mode_sel;
    logic [7:0] kfield;
    logic [7:0] devid;
    logic [7:0] linkctl;
    logic [7:0] inmux;
    logic [7:0] next_mode_sel;
    logic [7:0] next_kfield;
    logic [7:0] next_devid;
    logic [7:0] next_linkctl;
    logic [7:0] next_inmux;

    jmc_pkg::jmc_mode_t md;
    logic [7:0] k_eff;
    logic [7:0] sum_base;
    logic [7:0] lid_sel;
    logic [7:0] next_rdata;

    // ILAS octets in transmit order
    logic [7:0] oct_did;
    logic [7:0] oct_bid;
    logic [7:0] oct_adjcnt;
    logic [7:0] oct_adjdir;
    logic [7:0] oct_lm1;
    logic [7:0] oct_scr;
    logic [7:0] oct_fm1;
    logic [7:0] oct_kfld;
    logic [7:0] oct_mm1;
    logic [7:0] oct_cs;
    logic [7:0] oct_nm1;
    logic [7:0] oct_subv;
    logic [7:0] oct_npm1;
    logic [7:0] oct_jesdv;
    logic [7:0] oct_sm1;
    logic [7:0] oct_hd;
    logic [7:0] oct_cf;
    logic [7:0] oct_res1;
    logic [7:0] oct_res2;

    logic       next_ilas_en;
    logic       next_scramble_en;
    logic       next_sample_2x;
    logic       next_dual_input;
    wire  logic [7:0] next_lane_pwr;
    logic [7:0] next_k;
    logic [7:0] next_pll_ratio;
    logic [7:0] next_lid;
    logic [7:0] next_checksum;

    // Mode table decode; reserved codes give valid = 0
    always_comb
    begin
        md = '0;
        case (mode_sel) // RQ16 RQ22
            8'h05: md = {1'b1, 1'b1, jmc_pkg::JMC_ENC_8B10B, 4'h4,
                         8'h01, 8'h04, 8'h50};
            8'h06: md = {1'b1, 1'b1, jmc_pkg::JMC_ENC_8B10B, 4'h8,
                         8'h01, 8'h08, 8'h28};
            8'h07: md = {1'b1, 1'b0, jmc_pkg::JMC_ENC_8B10B, 4'h4,
                         8'h01, 8'h04, 8'h50};
            8'h08: md = {1'b1, 1'b0, jmc_pkg::JMC_ENC_8B10B, 4'h8,
                         8'h01, 8'h08, 8'h28};
            8'h22: md = {1'b1, 1'b1, jmc_pkg::JMC_ENC_64B66B, 4'h2,
                         8'h01, 8'h02, 8'h84};
            8'h23: md = {1'b1, 1'b0, jmc_pkg::JMC_ENC_64B66B, 4'h2,
                         8'h01, 8'h02, 8'h84};
            8'h2c: md = {1'b1, 1'b1, jmc_pkg::JMC_ENC_64B66B, 4'h4,
                         8'h01, 8'h04, 8'h42};
            8'h2d: md = {1'b1, 1'b0, jmc_pkg::JMC_ENC_64B66B, 4'h4,
                         8'h01, 8'h04, 8'h42};
            8'h32: md = {1'b1, 1'b1, jmc_pkg::JMC_ENC_64B66B, 4'h8,
                         8'h01, 8'h08, 8'h21};
            8'h33: md = {1'b1, 1'b0, jmc_pkg::JMC_ENC_64B66B, 4'h8,
                         8'h01, 8'h08, 8'h21};
            default: md = '0;
        endcase
    end

    // Effective K and ILAS field sum without the per-lane identifier
    always_comb
    begin
        if (md.enc == jmc_pkg::JMC_ENC_64B66B)
        begin
            k_eff = 8'hff; // RQ21 RQ8: 8*32*1/1 = 256, held as K-1
        end
        else
        begin
            k_eff = kfield; // RQ7
        end
        oct_did    = devid;                                // RQ13
        oct_bid    = 8'h00;                                // RQ11
        oct_adjcnt = 8'h00;                                // RQ10
        oct_adjdir = 8'h00;                                // RQ10
        oct_lm1    = 8'({4'h0, md.lanes} - 8'h01);         // RQ16
        oct_scr    = {7'h00, linkctl[`JMC_BIT_SCR]};       // RQ15
        oct_fm1    = 8'(md.f - 8'h01);                     // RQ16
        oct_kfld   = k_eff;
        oct_mm1    = 8'h00;                                // RQ17
        oct_cs     = 8'h00;                                // RQ12
        oct_nm1    = 8'h07;                                // RQ16
        oct_subv   = {5'h00, `JMC_SUBCLASSV};              // RQ19
        oct_npm1   = 8'h07;                                // RQ16
        oct_jesdv  = {5'h00, `JMC_JESDV};                  // RQ19
        oct_sm1    = 8'(md.s - 8'h01);                     // RQ16
        oct_hd     = 8'h00;                                // RQ11
        oct_cf     = 8'h00;                                // RQ11
        oct_res1   = 8'h00;                                // RQ11
        oct_res2   = 8'h00;                                // RQ11
        // Byte sum wraps, giving modulo 256
        sum_base = oct_did + oct_bid + oct_adjcnt + oct_adjdir
                 + oct_lm1 + oct_scr + oct_fm1 + oct_kfld
                 + oct_mm1 + oct_cs + oct_nm1 + oct_subv
                 + oct_npm1 + oct_jesdv + oct_sm1 + oct_hd
                 + oct_cf + oct_res1 + oct_res2;           // RQ18
        lid_sel = {5'h00, lane_sel_i}; // RQ14
    end

    // Register writes
    always_comb
    begin
        next_mode_sel = mode_sel;
        next_kfield   = kfield;
        next_devid    = devid;
        next_linkctl  = linkctl;
        next_inmux    = inmux;
        if (wr_i)
        begin
            case (addr_i)
                `JMC_OFF_MODE:    next_mode_sel = wdata_i; // RQ4
                `JMC_OFF_KFIELD:  next_kfield   = wdata_i;
                `JMC_OFF_DEVID:   next_devid    = wdata_i;
                `JMC_OFF_LINKCTL: next_linkctl  = wdata_i;
                `JMC_OFF_INMUX:   next_inmux    = wdata_i;
                default:          next_mode_sel = mode_sel;
            endcase
        end
    end

    // Register reads, data in the next cycle
    always_comb
    begin
        next_rdata = 8'h00;
        if (rd_i)
        begin
            case (addr_i)
                `JMC_OFF_MODE:    next_rdata = mode_sel;
                `JMC_OFF_KFIELD:  next_rdata = kfield;
                `JMC_OFF_DEVID:   next_rdata = devid;
                `JMC_OFF_LINKCTL: next_rdata = linkctl;
                `JMC_OFF_INMUX:   next_rdata = inmux;
                `JMC_OFF_DERIVED: next_rdata = {md.valid, md.des, md.enc,
                                                md.lanes}; // RQ5
                `JMC_OFF_RATE:    next_rdata = md.r_x32;
                `JMC_OFF_CHECKSUM: next_rdata = sum_base;
                default:          next_rdata = 8'h00;
            endcase
        end
    end

    // Next values of the derived link outputs
    always_comb
    begin
        next_ilas_en     = md.valid
                           && md.enc == jmc_pkg::JMC_ENC_8B10B; // RQ9
        next_scramble_en = linkctl[`JMC_BIT_SCR];               // RQ15
        next_sample_2x   = md.valid && md.des;                  // RQ1
        next_dual_input  = md.valid && md.des
                           && inmux[`JMC_BIT_DUALIN];           // RQ2
        next_k           = k_eff;                               // RQ7
        next_pll_ratio   = md.r_x32;                            // RQ6
        next_lid         = lid_sel;                             // RQ14
        next_checksum    = 8'(sum_base + lid_sel);              // RQ18
    end

    // Lowest lanes carry data, upper lanes powered down
    generate
        for (genvar g = 0; g < `JMC_LANES_PER_LINK; g++)
        begin : g_lane_pwr
            assign next_lane_pwr[g] = md.valid && (g < md.lanes); // RQ22
        end
    endgenerate

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode_sel        <= `JMC_RST_MODE;
            kfield          <= `JMC_RST_KFIELD;
            devid           <= `JMC_RST_DEVID;
            linkctl         <= `JMC_RST_LINKCTL;
            inmux           <= `JMC_RST_INMUX;
            rdata_o         <= 8'h00;
            ilas_en_o       <= 1'b0;
            scramble_en_o   <= 1'b0;
            sample_2x_o     <= 1'b0;
            dual_input_o    <= 1'b0;
            lane_pwr_o      <= 8'h00;
            k_o             <= 8'h00;
            pll_ratio_x32_o <= 8'h00;
            ilas_lid_o      <= 8'h00;
            ilas_checksum_o <= 8'h00;
        end
        else
        begin
            mode_sel        <= next_mode_sel;
            kfield          <= next_kfield;
            devid           <= next_devid;
            linkctl         <= next_linkctl;
            inmux           <= next_inmux;
            rdata_o         <= next_rdata;
            ilas_en_o       <= next_ilas_en;
            scramble_en_o   <= next_scramble_en;
            sample_2x_o     <= next_sample_2x;
            dual_input_o    <= next_dual_input;
            k_o             <= next_k;
            pll_ratio_x32_o <= next_pll_ratio;
            ilas_lid_o      <= next_lid;
            ilas_checksum_o <= next_checksum;
            lane_pwr_o      <= next_lane_pwr;
        end
    end

    // Interleave only alters analog routing; link fields ignore it: RQ3

endmodule

// ---- sim/jmc_rx_model.sv ----
// Receiver side model that recomputes the ILAS checksum
`timescale 1ns/1ns
module jmc_rx_model
(
    input  wire logic [7:0] did_i,
    input  wire logic [3:0] lanes_i,
    input  wire logic       scr_i,
    input  wire logic [7:0] kfield_i,
    input  wire logic [7:0] lid_i,
    input  wire logic [7:0] checksum_i,
    output logic      [7:0] sum_o,
    output logic            mismatch_o
);
    // S equals L; fixed octets add 10, the -1 of L-1 and S-1 takes 2, net 0e
    assign sum_o = did_i + {3'h0, lanes_i, 1'b0} + {7'h00, scr_i}
                   + kfield_i + lid_i + 8'h0e;
    assign mismatch_o = sum_o !== checksum_i;
endmodule

// ---- sim/jmc_mode_ilas_chk.sv ----
// Port assertions for the mode and ILAS block
`timescale 1ns/1ns
module jmc_mode_ilas_chk
(
    input wire logic       clock_i,
    input wire logic       rst_i,
    input wire logic       wr_i,
    input wire logic [2:0] lane_sel_i,
    input wire logic       ilas_en_o,
    input wire logic       sample_2x_o,
    input wire logic       dual_input_o,
    input wire logic [7:0] lane_pwr_o,
    input wire logic [7:0] k_o,
    input wire logic [7:0] pll_ratio_x32_o,
    input wire logic [7:0] ilas_lid_o,
    input wire logic [7:0] ilas_checksum_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire logic [7:0] base = ilas_checksum_o - ilas_lid_o;
    property p_dual; dual_input_o |-> sample_2x_o; endproperty
    a_dual: assert property (p_dual) else $error("dual no 2x");
    property p_x2; sample_2x_o |-> pll_ratio_x32_o != 8'h00; endproperty
    a_x2: assert property (p_x2) else $error("2x bad mode");
    property p_lid; 1'b1 |=> ilas_lid_o[2:0] == $past(lane_sel_i); endproperty
    a_lid: assert property (p_lid) else $error("lid");
    property p_pwr; lane_pwr_o inside {8'h00, 8'h03, 8'h0f, 8'hff}; endproperty
    a_pwr: assert property (p_pwr) else $error("lane power");
    property p_k; !ilas_en_o && pll_ratio_x32_o != 8'h00 |-> k_o == 8'hff;
    endproperty
    a_k: assert property (p_k) else $error("k 64b");
    property p_en; ilas_en_o |-> pll_ratio_x32_o inside {8'h50, 8'h28};
    endproperty
    a_en: assert property (p_en) else $error("ilas mode");
    property p_r; pll_ratio_x32_o == 8'h50 |-> lane_pwr_o == 8'h0f; endproperty
    a_r: assert property (p_r) else $error("rate lanes");
    property p_sum; !$past(wr_i, 2) && !$past(rst_i, 2) && !$past(rst_i)
        |-> base == $past(base); endproperty
    a_sum: assert property (p_sum) else $error("sum");
endmodule
bind jmc_mode_ilas jmc_mode_ilas_chk chk_u (.*);

// ---- sim/tb_jmc_mode_ilas.sv ----
// Testbench for mode decode and ILAS fields
`timescale 1ns/1ns
module tb_jmc_mode_ilas;
    logic clock_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, scr = 1'b0;
    logic [3:0] addr_i = 4'h0, lanes = 4'h8;
    logic [2:0] lane_sel_i = 3'h0;
    logic [7:0] wdata_i = 8'h00, did = 8'h00, kval = 8'h1f, sum_o;
    logic [7:0] rdata_o, lane_pwr_o, k_o, pll_ratio_x32_o;
    logic [7:0] ilas_lid_o, ilas_checksum_o;
    logic ilas_en_o, scramble_en_o, sample_2x_o, dual_input_o, bad;
    logic [7:0] md [12] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h22, 8'h23,
                            8'h2c, 8'h2d, 8'h32, 8'h33, 8'h00, 8'h09};
    logic [7:0] der [12] = '{8'hd4, 8'hd8, 8'h94, 8'h98, 8'he2, 8'ha2,
                             8'he4, 8'ha4, 8'he8, 8'ha8, 8'h00, 8'h00};
    logic [7:0] pl [12] = '{8'h50, 8'h28, 8'h50, 8'h28, 8'h84, 8'h84,
                            8'h42, 8'h42, 8'h21, 8'h21, 8'h00, 8'h00};
    int n_errors = 0, n_tests = 0, cyc = 0;
    jmc_mode_ilas dut_u (.*);
    jmc_rx_model rx_u (.did_i(did), .lanes_i(lanes), .scr_i(scr),
        .kfield_i(kval), .lid_i(ilas_lid_o), .checksum_i(ilas_checksum_o),
        .sum_o(sum_o), .mismatch_o(bad));
    initial forever #25 clock_i = ~clock_i;
    task give_verdict;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clock_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        n_tests++;
        if (s !== e)
        begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(negedge clock_i);
        chk("rdata", e, rdata_o);
    endtask
    task t_reset;
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h1f);
        rd(4'h2, 8'h00);
        rd(4'h3, 8'h00);
        rd(4'h4, 8'h00);
        rd(4'h8, 8'h00);
    endtask
    task t_modes;
        for (int i = 0; i < 12; i++)
        begin
            wr(4'h0, md[i]);
            rd(4'h5, der[i]);
            rd(4'h6, pl[i]);
            chk("pll", pl[i], pll_ratio_x32_o);
            chk("2x", {7'h0, der[i][6]}, {7'h0, sample_2x_o});
            chk("ilas", {7'h0, der[i][4]}, {7'h0, ilas_en_o});
            chk("pwr", 8'((9'h1 << der[i][3:0]) - 9'h1), lane_pwr_o);
            if (der[i][7])
                chk("k", der[i][5] ? 8'hff : 8'h1f, k_o);
        end
    endtask
    task t_dual;
        wr(4'h0, 8'h05);
        wr(4'h4, 8'h01);
        @(negedge clock_i);
        chk("dual", 8'h01, {7'h0, dual_input_o});
        rd(4'h5, 8'hd4);
        wr(4'h0, 8'h07);
        @(negedge clock_i);
        chk("dual", 8'h00, {7'h0, dual_input_o});
    endtask
    task t_ilas;
        did = 8'ha5;
        scr = 1'b1;
        kval = 8'h3f;
        wr(4'h0, 8'h06);
        wr(4'h2, did);
        wr(4'h3, 8'h01);
        wr(4'h1, kval);
        wr(4'h5, 8'hff);
        rd(4'h5, 8'hd8);
        rd(4'h7, sum_o);
        rd(4'h2, 8'ha5);
        chk("scr", 8'h01, {7'h0, scramble_en_o});
        chk("k8", 8'h3f, k_o);
        for (int l = 0; l < 8; l++)
        begin
            @(posedge clock_i);
            lane_sel_i <= 3'(l);
            @(posedge clock_i);
            @(negedge clock_i);
            chk("lid", 8'(l), ilas_lid_o);
            chk("sum", sum_o, ilas_checksum_o);
            chk("rx", 8'h00, {7'h0, bad});
        end
        wr(4'h0, 8'h22);
        @(negedge clock_i);
        chk("k64", 8'hff, k_o);
    endtask
    initial
    begin
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        t_reset();
        t_modes();
        t_dual();
        t_ilas();
        give_verdict();
    end
endmodule
